// >>> rtl/branch_call_config_exec.v
// Execute stage for branch, call, complement, compare and RAM configuration
`timescale 1ns/1ps
`default_nettype none
`include "branch_call_config_regs.vh"

// How it works
// - A branch on zero loads the operand address into the PC only if the accumulator is zero, else PC steps by two.
// - A computed call pushes PC plus one onto the stack top, then loads PC from accumulator bits 15 to 0.
// - The complement instruction inverts every accumulator bit.
// - The aux compare tests the selected aux register against register zero unsigned by the compare code and sets the test flag.
// - Configure-as-data clears the RAM config bit, which shows only in the status word and leaves the block map unchanged.
// - The two-bit config field maps blocks: 00 all data, 01 block0, 10 blocks 0 and 1, 11 blocks 0, 1 and 3 program.
// - The two-bit configure instruction copies constant bit 1 to the high config bit and bit 0 to the low one.
// - Disable-interrupts sets the interrupt mode bit to one, masking maskable interrupts.
module branch_call_config_exec (
    input  wire        mclk,
    input  wire        reset,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [3:0]  program_blocks_q
);
    // Architectural state of the core slice
    reg [15:0] pc_q;
    reg [31:0] acc_q;
    reg [15:0] stack_top_q;
    reg [15:0] operand_q;
    reg [2:0]  aux_pointer_q;
    reg [15:0] aux_q [0:7];
    reg        test_flag_q;
    reg        ram_config_bit_q;
    reg        ram_config_low_bit_q;
    reg        ram_config_high_bit_q;
    reg        interrupt_mode_bit_q;

    // Write channel capture; address and data may arrive in either order
    reg        aw_held_q;
    reg [7:0]  aw_addr_q;
    reg        w_held_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    wire       wr_go;
    wire [7:0] wr_addr;
    wire [31:0] wr_merged;
    wire [31:0] wr_mask;
    wire       wr_aux;
    wire [2:0] wr_aux_idx;

    assign wr_go      = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign wr_addr    = aw_addr_q;
    assign wr_mask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}}, {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_aux     = (wr_addr[7:5] == 3'b001) & (wr_addr[1:0] == 2'b00);
    assign wr_aux_idx = wr_addr[4:2];
    assign wr_merged  = w_data_q & wr_mask;

    // Command decode: writing COMMAND executes one instruction that cycle
    wire       cmd_go;
    wire [3:0] cmd_op;
    wire [1:0] cmd_const;
    wire [2:0] cmd_next_ptr;
    wire       cmd_ptr_upd;
    wire       cmd_aux_upd;
    wire [15:0] cmd_aux_val;
    assign cmd_go       = wr_go & (wr_addr == `REG_COMMAND) & w_strb_q[0];
    assign cmd_op       = w_data_q[3:0];
    assign cmd_const    = w_data_q[5:4];
    assign cmd_aux_upd  = w_data_q[8];
    assign cmd_ptr_upd  = w_data_q[9];
    assign cmd_next_ptr = w_data_q[12:10];
    assign cmd_aux_val  = w_data_q[31:16];

    // Unsigned compare of selected aux register with register zero
    wire [15:0] cur_aux;
    reg         cmp_true;
    assign cur_aux = aux_q[aux_pointer_q];
    always @*
    begin
        case (cmd_const)
            2'b00:   cmp_true = (cur_aux == aux_q[0]);
            2'b01:   cmp_true = (cur_aux <  aux_q[0]);
            2'b10:   cmp_true = (cur_aux >  aux_q[0]);
            default: cmp_true = (cur_aux != aux_q[0]);
        endcase
    end

    // Bus write handshake
    always @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held_q     <= 1'b0;
            w_held_q      <= 1'b0;
            aw_addr_q     <= 8'h00;
            w_data_q      <= 32'h00000000;
            w_strb_q      <= 4'h0;
        end
        else
        begin
            s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid & s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go)
            begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Only command, operand, accumulator, PC, pointer and aux words are writable
                if (wr_addr == `REG_COMMAND || wr_addr == `REG_ACC || wr_addr == `REG_PC ||
                    wr_addr == `REG_AUX_SEL || wr_addr == `REG_OPERAND || wr_aux)
                    s_axi_bresp <= `RESP_OKAY;
                else
                    s_axi_bresp <= `RESP_SLVERR;
            end
            else if (s_axi_bvalid & s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Instruction execution and direct register writes
    always @(posedge mclk)
    begin
        if (reset)
        begin
            pc_q                  <= `RESET_PC;
            acc_q                 <= `RESET_ACC;
            stack_top_q           <= 16'h0000;
            operand_q             <= 16'h0000;
            aux_pointer_q         <= 3'h0;
            test_flag_q           <= 1'b0;
            ram_config_bit_q      <= 1'b0;
            ram_config_low_bit_q  <= 1'b0;
            ram_config_high_bit_q <= 1'b0;
            interrupt_mode_bit_q  <= 1'b1;
        end
        else if (cmd_go)
        begin
            case (cmd_op)
                `OP_BRANCH_ZERO:
                begin
                    if (acc_q == 32'h00000000)
                        pc_q <= operand_q;
                    else
                        pc_q <= pc_q + 16'h0002;
                    if (cmd_ptr_upd)
                        aux_pointer_q <= cmd_next_ptr;
                end
                `OP_COMPUTED_CALL:
                begin
                    stack_top_q <= pc_q + 16'h0001;
                    pc_q        <= acc_q[15:0];
                end
                `OP_DIRECT_CALL:
                begin
                    stack_top_q <= pc_q + 16'h0002;
                    pc_q        <= operand_q;
                    if (cmd_ptr_upd)
                        aux_pointer_q <= cmd_next_ptr;
                end
                `OP_COMPLEMENT:
                begin
                    acc_q <= ~acc_q;
                    pc_q  <= pc_q + 16'h0001;
                end
                `OP_AUX_COMPARE:
                begin
                    test_flag_q <= cmp_true;
                    pc_q        <= pc_q + 16'h0001;
                end
                `OP_CONFIG_DATA:
                begin
                    ram_config_bit_q <= 1'b0;
                    pc_q             <= pc_q + 16'h0001;
                end
                `OP_CONFIG_PROG:
                begin
                    ram_config_bit_q <= 1'b1;
                    pc_q             <= pc_q + 16'h0001;
                end
                `OP_CONFIG_MODE:
                begin
                    ram_config_high_bit_q <= cmd_const[1];
                    ram_config_low_bit_q  <= cmd_const[0];
                    pc_q                  <= pc_q + 16'h0001;
                end
                `OP_DISABLE_INT:
                begin
                    interrupt_mode_bit_q <= 1'b1;
                    pc_q                 <= pc_q + 16'h0001;
                end
                default:
                    pc_q <= pc_q + 16'h0001;
            endcase
        end
        else if (wr_go)
        begin
            if (wr_addr == `REG_ACC)
                acc_q <= (acc_q & ~wr_mask) | wr_merged;
            if (wr_addr == `REG_PC)
                pc_q <= w_data_q[15:0];
            if (wr_addr == `REG_OPERAND)
                operand_q <= w_data_q[15:0];
            if (wr_addr == `REG_AUX_SEL)
                aux_pointer_q <= w_data_q[2:0];
        end
    end

    // Aux register file: one writer per entry, by bus or by direct call or branch-on-zero update
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : aux_file
            // Entry index at pointer width, so compares stay 3 bits wide
            localparam [2:0] AUX_IDX = gi;
            always @(posedge mclk)
            begin
                if (reset)
                    aux_q[gi] <= 16'h0000;
                else if (cmd_go && (cmd_op == `OP_DIRECT_CALL || cmd_op == `OP_BRANCH_ZERO) &&
                         cmd_aux_upd && aux_pointer_q == AUX_IDX)
                    aux_q[gi] <= cmd_aux_val;
                else if (wr_go && wr_aux && wr_aux_idx == AUX_IDX)
                    aux_q[gi] <= w_data_q[15:0];
            end
        end
    endgenerate

    // Block map decoded from the two-bit mode, block two always data
    always @(posedge mclk)
    begin
        if (reset)
            program_blocks_q <= 4'h0;
        else
        begin
            case ({ram_config_high_bit_q, ram_config_low_bit_q})
                2'b00:   program_blocks_q <= 4'h0;
                2'b01:   program_blocks_q <= 4'h1;
                2'b10:   program_blocks_q <= 4'h3;
                default: program_blocks_q <= 4'hB;
            endcase
        end
    end

    // Bus read; answer one cycle after address is taken
    wire [31:0] status_word;
    assign status_word = {27'h0, interrupt_mode_bit_q, ram_config_high_bit_q,
                          ram_config_low_bit_q, ram_config_bit_q, test_flag_q};
    always @(posedge mclk)
    begin
        if (reset)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                if (s_axi_araddr[7:5] == 3'b001 && s_axi_araddr[1:0] == 2'b00)
                    s_axi_rdata <= {16'h0000, aux_q[s_axi_araddr[4:2]]};
                else
                begin
                    case (s_axi_araddr)
                        `REG_COMMAND:   s_axi_rdata <= 32'h00000000;
                        `REG_OPERAND:   s_axi_rdata <= {16'h0000, operand_q};
                        `REG_ACC:       s_axi_rdata <= acc_q;
                        `REG_PC:        s_axi_rdata <= {16'h0000, pc_q};
                        `REG_STACK_TOP: s_axi_rdata <= {16'h0000, stack_top_q};
                        `REG_STATUS:    s_axi_rdata <= status_word;
                        `REG_AUX_SEL:   s_axi_rdata <= {29'h0, aux_pointer_q};
                        default:
                        begin
                            s_axi_rdata <= 32'h00000000;
                            s_axi_rresp <= `RESP_SLVERR;
                        end
                    endcase
                end
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> shared/branch_call_config_regs.vh
// Register offsets, field positions, reset values and opcodes of the execute block
`ifndef BRANCH_CALL_CONFIG_REGS_VH
`define BRANCH_CALL_CONFIG_REGS_VH
`define REG_COMMAND      8'h00
`define REG_OPERAND      8'h04
`define REG_ACC          8'h08
`define REG_PC           8'h0C
`define REG_STACK_TOP    8'h10
`define REG_STATUS       8'h14
`define REG_AUX_SEL      8'h18
`define REG_AUX_BASE     8'h20
`define OP_BRANCH_ZERO   4'h1
`define OP_COMPUTED_CALL 4'h2
`define OP_DIRECT_CALL   4'h3
`define OP_COMPLEMENT    4'h4
`define OP_AUX_COMPARE   4'h5
`define OP_CONFIG_DATA   4'h6
`define OP_CONFIG_PROG   4'h7
`define OP_CONFIG_MODE   4'h8
`define OP_DISABLE_INT   4'h9
`define ST_TEST_FLAG     0
`define ST_CFG_BIT       1
`define ST_CFG_LOW       2
`define ST_CFG_HIGH      3
`define ST_INT_MODE      4
`define RESET_PC         16'h0000
`define RESET_ACC        32'h00000000
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10
`endif

// >>> sim/branch_call_config_checker.sv
// Assertions on the bus handshakes and RAM block map of the execute block
`timescale 1ns/1ps
`default_nettype none
module branch_call_config_checker (
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [3:0]  program_blocks_q
);
    default clocking dck @(posedge mclk);
    endclocking
    default disable iff (reset);

    // Only the four block maps exist; block two never becomes program
    a_map_legal: assert property (
        program_blocks_q inside {4'h0, 4'h1, 4'h3, 4'hB}) else $error("illegal block map");
    // Map moves only behind a write response, never on its own
    a_map_after_write: assert property (
        $changed(program_blocks_q) |-> $past(s_axi_bvalid)) else $error("map changed unprompted");
    a_bvalid_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped early");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer not held");
    a_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_awready_pulse: assert property (
        s_axi_awready |=> !s_axi_awready) else $error("awready longer than a pulse");
    a_bresp_legal: assert property (
        s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2}) else $error("odd write response");
    a_rvalid_cause: assert property ($rose(s_axi_rvalid)
        |-> $past(s_axi_arvalid && s_axi_arready)) else $error("read answer without request");
endmodule

bind branch_call_config_exec branch_call_config_checker u_checker (
    .mclk, .reset, .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .program_blocks_q
);
`default_nettype wire

// >>> sim/branch_call_config_exec_bench.sv
// Self-checking bench for the branch, call and RAM configuration execute block
`timescale 1ns/1ps
`default_nettype none
`include "branch_call_config_regs.vh"
module branch_call_config_exec_bench;
    logic        mclk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, got_data;
    logic [3:0]  s_axi_wstrb, program_blocks_q;
    logic [1:0]  s_axi_bresp, s_axi_rresp, got_resp;
    int          bad_count, checked;

    branch_call_config_exec u_dut (
        .mclk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .program_blocks_q
    );

    // 100 MHz core clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw = 1;
        bit w = 1;
        bit b = 1;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (b)
        begin
            @(posedge mclk);
            aw = aw && !s_axi_awready;
            w = w && !s_axi_wready;
            b = !s_axi_bvalid;
            got_resp = s_axi_bresp;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
            s_axi_bready <= b;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        bit ar = 1;
        bit r = 1;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (r)
        begin
            @(posedge mclk);
            ar = ar && !s_axi_arready;
            r = !s_axi_rvalid;
            got_data = s_axi_rdata;
            got_resp = s_axi_rresp;
            s_axi_arvalid <= ar;
            s_axi_rready <= r;
        end
    endtask

    // Masked read compare, so unknown field widths stay out of the way
    task expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk({30'h0, got_resp}, {30'h0, `RESP_OKAY});
        chk(got_data & m, e);
    endtask

    task t_reset;
        expect_reg(`REG_PC, 32'hFFFF, 32'h0);
        expect_reg(`REG_STATUS, 32'h1F, 32'h10);
        chk({28'h0, program_blocks_q}, 32'h0);
        $display("t_reset done");
    endtask

    task t_branch;
        wr(`REG_OPERAND, 32'h1234);
        chk({30'h0, got_resp}, {30'h0, `RESP_OKAY});
        wr(`REG_ACC, 32'h0);
        wr(`REG_PC, 32'h0010);
        wr(`REG_COMMAND, `OP_BRANCH_ZERO);
        expect_reg(`REG_PC, 32'hFFFF, 32'h1234);
        wr(`REG_ACC, 32'h10000); // Nonzero only in the upper half
        wr(`REG_PC, 32'h0010);
        wr(`REG_COMMAND, `OP_BRANCH_ZERO);
        expect_reg(`REG_PC, 32'hFFFF, 32'h0012);
        $display("t_branch done");
    endtask

    task t_calls;
        wr(`REG_PC, 32'h0100);
        wr(`REG_ACC, 32'hABCD5678);
        wr(`REG_COMMAND, `OP_COMPUTED_CALL);
        expect_reg(`REG_STACK_TOP, 32'hFFFF, 32'h0101);
        expect_reg(`REG_PC, 32'hFFFF, 32'h5678);
        wr(`REG_OPERAND, 32'h3456);
        wr(`REG_AUX_SEL, 32'h2);
        wr(`REG_COMMAND, 32'h00771703); // Aux 2 gets 0x77, pointer goes to 5
        expect_reg(`REG_STACK_TOP, 32'hFFFF, 32'h567A);
        expect_reg(`REG_PC, 32'hFFFF, 32'h3456);
        expect_reg(`REG_AUX_BASE + 8'h08, 32'hFFFF, 32'h0077);
        expect_reg(`REG_AUX_SEL, 32'h7, 32'h5);
        wr(`REG_ACC, 32'h0F0F1234);
        wr(`REG_COMMAND, `OP_COMPLEMENT);
        expect_reg(`REG_ACC, 32'hFFFFFFFF, 32'hF0F0EDCB);
        $display("t_calls done");
    endtask

    // 0x8000 is above 5 only when compared unsigned
    task automatic t_compare;
        logic [15:0] v;
        logic        e;
        wr(`REG_AUX_BASE, 32'h5);
        wr(`REG_AUX_SEL, 32'h1);
        for (int i = 0; i < 3; i++)
            for (int c = 0; c < 4; c++)
            begin
                v = (i == 0) ? 16'h0005 : (i == 1) ? 16'h0003 : 16'h8000;
                e = c == 0 ? v == 5 : c == 1 ? v < 5 : c == 2 ? v > 5 : v != 5;
                wr(`REG_AUX_BASE + 8'h04, {16'h0, v});
                wr(`REG_COMMAND, 32'(c << 4) | `OP_AUX_COMPARE);
                expect_reg(`REG_STATUS, 32'h1, {31'h0, e});
            end
        $display("t_compare done");
    endtask

    task automatic t_config;
        logic [3:0] m;
        for (int k = 0; k < 4; k++)
        begin
            m = (k == 0) ? 4'h0 : (k == 1) ? 4'h1 : (k == 2) ? 4'h3 : 4'hB;
            wr(`REG_COMMAND, 32'(k << 4) | `OP_CONFIG_MODE);
            expect_reg(`REG_STATUS, 32'hC, 32'(k << 2));
            chk({28'h0, program_blocks_q}, {28'h0, m});
        end
        wr(`REG_COMMAND, `OP_CONFIG_PROG);
        expect_reg(`REG_STATUS, 32'h2, 32'h2);
        wr(`REG_COMMAND, `OP_CONFIG_DATA);
        expect_reg(`REG_STATUS, 32'h2, 32'h0);
        wr(`REG_COMMAND, `OP_DISABLE_INT);
        expect_reg(`REG_STATUS, 32'h10, 32'h10);
        $display("t_config done");
    endtask

    task t_refuse;
        rd(8'h40);
        chk({30'h0, got_resp}, {30'h0, `RESP_SLVERR});
        chk(got_data, 32'h0);
        wr(`REG_STATUS, 32'h0);
        chk({30'h0, got_resp}, {30'h0, `RESP_SLVERR});
        expect_reg(`REG_STATUS, 32'h10, 32'h10); // Read-only status kept
        $display("t_refuse done");
    endtask

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Run takes a few hundred cycles; the limit leaves ample margin
    initial
    begin
        #50us;
        bad_count++;
        end_sim;
    end

    initial
    begin
        reset = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        bad_count = 0;
        checked = 0;
        repeat (4) @(posedge mclk);
        reset <= 1'b0;
        t_reset;
        t_branch;
        t_calls;
        t_compare;
        t_config;
        t_refuse;
        end_sim;
    end
endmodule
`default_nettype wire
